// ==== common/csi_timing_defs.svh ====
// Offsets, field positions, reset values and counts of the lane timing registers
`ifndef CSI_TIMING_DEFS_SVH
`define CSI_TIMING_DEFS_SVH
`define CSI_ADDR_W        8
`define CSI_DATA_W        8
`define CSI_VAL_W         7
`define CSI_NUM_REGS      7
`define CSI_IDX_W         3
`define CSI_OFS_CLK_PREP  8'h40
`define CSI_OFS_CLK_ZERO  8'h41
`define CSI_OFS_CLK_TRAIL 8'h42
`define CSI_OFS_CLK_POST  8'h43
`define CSI_OFS_HS_PREP   8'h44
`define CSI_OFS_HS_ZERO   8'h45
`define CSI_OFS_HS_TRAIL  8'h46
`define CSI_IDX_CLK_PREP  3'h0
`define CSI_IDX_CLK_ZERO  3'h1
`define CSI_IDX_CLK_TRAIL 3'h2
`define CSI_IDX_CLK_POST  3'h3
`define CSI_IDX_HS_PREP   3'h4
`define CSI_IDX_HS_ZERO   3'h5
`define CSI_IDX_HS_TRAIL  3'h6
`define CSI_OV_BIT        7
`define CSI_VAL_MSB       6
`define CSI_OV_RESET      1'h0
`define CSI_VAL_RESET     7'h00
`define CSI_UNMAPPED_RD   8'h00
`define CSI_MIN_PHASE     7'h01
`endif

// ==== common/csi_timing_pkg.sv ====
// Types shared by the lane timing override block
`default_nettype none
package csi_timing_pkg;
  // Seven timing values; clk_prepare lands at element 0 of a packed array
  typedef struct packed {
    logic [6:0] hs_trail;
    logic [6:0] hs_zero;
    logic [6:0] hs_prepare;
    logic [6:0] clk_post;
    logic [6:0] clk_trail;
    logic [6:0] clk_zero;
    logic [6:0] clk_prepare;
  } timing_set_t;

  // Lane drive controls toward the analog lanes
  typedef struct packed {
    logic clk_prep;
    logic clk_hs;
    logic data_prep;
    logic data_hs;
    logic tx_ready;
    logic busy;
  } lane_ctrl_t;

  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_CLK_PREP  = 9'h002,
    ST_CLK_ZERO  = 9'h004,
    ST_HS_PREP   = 9'h008,
    ST_HS_ZERO   = 9'h010,
    ST_HS_ACTIVE = 9'h020,
    ST_HS_TRAIL  = 9'h040,
    ST_CLK_POST  = 9'h080,
    ST_CLK_TRAIL = 9'h100
  } seq_state_t;
endpackage
`default_nettype wire

// ==== hw/csi_dphy_timing_override_regs.sv ====
// Lane timing override registers and the low-power to high-speed sequencer
//
// Summary of operation
// RULE1: Clock prepare: bit 7 picks auto or software.
// RULE2: Clock zero: bit 7 picks auto or software.
// RULE3: Clock trail: bit 7 picks auto or software.
// RULE4: Clock post: bit 7 picks auto or software.
// RULE5: HS prepare: bit 7 picks auto or software.
// RULE6: HS zero: bit 7 picks auto or software.
// RULE7: HS trail: bit 7 picks auto or software.
// RULE8: Override clear: value field reads automatic value.
// RULE9: Override set: value field writable and readable.
// RULE10: Lane transitions use the value in effect.
`timescale 1ns/10ps
`default_nettype none
`include "csi_timing_defs.svh"

module csi_dphy_timing_override_regs (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic [`CSI_ADDR_W-1:0]    reg_addr,
  input  wire logic [`CSI_DATA_W-1:0]    reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [`CSI_DATA_W-1:0]         reg_rdata,
  input  wire csi_timing_pkg::timing_set_t auto_timing,
  output csi_timing_pkg::timing_set_t    eff_timing,
  input  wire logic                      hs_req,
  output csi_timing_pkg::lane_ctrl_t     lane_ctrl
);

  // Reset released through two flops
  logic                      rst_meta_n;
  logic                      rst_sync_n;

  // Register contents
  logic [`CSI_NUM_REGS-1:0]  ov;
  logic [`CSI_VAL_W-1:0]     val [`CSI_NUM_REGS];

  // Array views of the timing sets
  logic [`CSI_NUM_REGS-1:0][`CSI_VAL_W-1:0] auto_arr;
  logic [`CSI_NUM_REGS-1:0][`CSI_VAL_W-1:0] eff_arr;

  // Address decode
  logic                      hit;
  logic [`CSI_IDX_W-1:0]     idx;

  // Sequencer
  csi_timing_pkg::seq_state_t state;
  csi_timing_pkg::seq_state_t next_state;
  logic [`CSI_VAL_W-1:0]     cnt;
  logic [`CSI_VAL_W-1:0]     next_cnt;

  // Offset to register index; shared by write and read paths
  function automatic logic [`CSI_IDX_W:0] decode(
    input logic [`CSI_ADDR_W-1:0] a
  );
    logic [`CSI_ADDR_W-1:0] d;
    d = a - `CSI_OFS_CLK_PREP;
    if (a >= `CSI_OFS_CLK_PREP && a <= `CSI_OFS_HS_TRAIL) begin
      decode = {1'b1, d[`CSI_IDX_W-1:0]};
    end else begin
      decode = {1'b0, `CSI_IDX_W'(0)};
    end
  endfunction

  // A zero value would never count down to the exit; hold each phase a cycle at least
  function automatic logic [`CSI_VAL_W-1:0] phase_len(
    input logic [`CSI_VAL_W-1:0] v
  );
    phase_len = (v == `CSI_VAL_RESET) ? `CSI_MIN_PHASE : v;
  endfunction

  // Lane drive seen in each sequencer state
  function automatic csi_timing_pkg::lane_ctrl_t lane_code(
    input csi_timing_pkg::seq_state_t s
  );
    csi_timing_pkg::lane_ctrl_t l;
    l = '0;
    l.busy = (s != csi_timing_pkg::ST_IDLE);
    l.clk_prep = (s == csi_timing_pkg::ST_CLK_PREP);
    l.clk_hs = l.busy && !l.clk_prep;
    l.data_prep = (s == csi_timing_pkg::ST_HS_PREP);
    l.data_hs = (s == csi_timing_pkg::ST_HS_ZERO)
             || (s == csi_timing_pkg::ST_HS_ACTIVE)
             || (s == csi_timing_pkg::ST_HS_TRAIL);
    l.tx_ready = (s == csi_timing_pkg::ST_HS_ACTIVE);
    lane_code = l;
  endfunction

  // Reset synchroniser; first flop feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  assign auto_arr = auto_timing;
  assign {hit, idx} = decode(reg_addr);

  // Per-register storage, selection and write rules
  generate
    for (genvar i = 0; i < `CSI_NUM_REGS; i++) begin : g_reg
      // Bit 7 always writable; value field written only by a write that sets bit 7
      always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          ov[i]  <= `CSI_OV_RESET;
          val[i] <= `CSI_VAL_RESET;
        end else if (reg_wr && hit && idx == `CSI_IDX_W'(i)) begin
          ov[i] <= reg_wdata[`CSI_OV_BIT];
          if (reg_wdata[`CSI_OV_BIT]) begin // RULE9
            val[i] <= reg_wdata[`CSI_VAL_MSB:0];
          end
        end
      end

      // Value in effect: software copy or derived value
      assign eff_arr[i] = ov[i] ? val[i] : auto_arr[i];
    end
  endgenerate

  // Named per parameter so each selection is visible
  assign eff_timing.clk_prepare = eff_arr[`CSI_IDX_CLK_PREP];  // RULE1
  assign eff_timing.clk_zero    = eff_arr[`CSI_IDX_CLK_ZERO];  // RULE2
  assign eff_timing.clk_trail   = eff_arr[`CSI_IDX_CLK_TRAIL]; // RULE3
  assign eff_timing.clk_post    = eff_arr[`CSI_IDX_CLK_POST];  // RULE4
  assign eff_timing.hs_prepare  = eff_arr[`CSI_IDX_HS_PREP];   // RULE5
  assign eff_timing.hs_zero     = eff_arr[`CSI_IDX_HS_ZERO];   // RULE6
  assign eff_timing.hs_trail    = eff_arr[`CSI_IDX_HS_TRAIL];  // RULE7

  // Read data one cycle after the strobe; the value field mirrors what is in use
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= `CSI_UNMAPPED_RD;
    end else if (reg_rd && hit) begin
      reg_rdata <= {ov[idx], eff_arr[idx]}; // RULE8 RULE9
    end else begin
      reg_rdata <= `CSI_UNMAPPED_RD;
    end
  end

  // Phase sequencing; each phase length taken from the value in effect
  always_comb begin
    next_state = state;
    next_cnt   = (cnt > `CSI_MIN_PHASE) ? cnt - `CSI_MIN_PHASE : cnt;
    unique case (state)
      csi_timing_pkg::ST_IDLE: begin
        if (hs_req) begin
          next_state = csi_timing_pkg::ST_CLK_PREP;
          next_cnt   = phase_len(eff_timing.clk_prepare); // RULE10
        end
      end
      csi_timing_pkg::ST_CLK_PREP: begin
        if (cnt == `CSI_MIN_PHASE) begin
          next_state = csi_timing_pkg::ST_CLK_ZERO;
          next_cnt   = phase_len(eff_timing.clk_zero); // RULE10
        end
      end
      csi_timing_pkg::ST_CLK_ZERO: begin
        if (cnt == `CSI_MIN_PHASE) begin
          next_state = csi_timing_pkg::ST_HS_PREP;
          next_cnt   = phase_len(eff_timing.hs_prepare); // RULE10
        end
      end
      csi_timing_pkg::ST_HS_PREP: begin
        if (cnt == `CSI_MIN_PHASE) begin
          next_state = csi_timing_pkg::ST_HS_ZERO;
          next_cnt   = phase_len(eff_timing.hs_zero); // RULE10
        end
      end
      csi_timing_pkg::ST_HS_ZERO: begin
        if (cnt == `CSI_MIN_PHASE) begin
          next_state = csi_timing_pkg::ST_HS_ACTIVE;
        end
      end
      csi_timing_pkg::ST_HS_ACTIVE: begin
        if (!hs_req) begin
          next_state = csi_timing_pkg::ST_HS_TRAIL;
          next_cnt   = phase_len(eff_timing.hs_trail); // RULE10
        end
      end
      csi_timing_pkg::ST_HS_TRAIL: begin
        // Clock keeps running past the data so the receiver can finish
        if (cnt == `CSI_MIN_PHASE) begin
          next_state = csi_timing_pkg::ST_CLK_POST;
          next_cnt   = phase_len(eff_timing.clk_post); // RULE10
        end
      end
      csi_timing_pkg::ST_CLK_POST: begin
        if (cnt == `CSI_MIN_PHASE) begin
          next_state = csi_timing_pkg::ST_CLK_TRAIL;
          next_cnt   = phase_len(eff_timing.clk_trail); // RULE10
        end
      end
      csi_timing_pkg::ST_CLK_TRAIL: begin
        if (cnt == `CSI_MIN_PHASE) begin
          next_state = csi_timing_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = csi_timing_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer state and phase counter
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= csi_timing_pkg::ST_IDLE;
      cnt   <= `CSI_MIN_PHASE;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Lane controls registered so they change glitch-free with the state
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lane_ctrl <= '0;
    end else begin
      lane_ctrl <= lane_code(next_state);
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n);

  // Write of an override value, then its effect a cycle later
  sequence s_ovr_wr(logic [`CSI_ADDR_W-1:0] a);
    reg_wr && reg_addr == a && reg_wdata[`CSI_OV_BIT];
  endsequence

  property p_clk_prepare;
    s_ovr_wr(`CSI_OFS_CLK_PREP) |=>
      eff_timing.clk_prepare == $past(reg_wdata[`CSI_VAL_MSB:0]);
  endproperty
  a_clk_prepare: assert property (p_clk_prepare) // RULE1
    else $error("clock prepare override not applied");

  property p_clk_zero;
    !ov[`CSI_IDX_CLK_ZERO] |-> eff_timing.clk_zero == auto_timing.clk_zero;
  endproperty
  a_clk_zero: assert property (p_clk_zero) // RULE2
    else $error("clock zero not following automatic value");

  property p_clk_trail;
    s_ovr_wr(`CSI_OFS_CLK_TRAIL) ##1 !reg_wr[*2] |->
      eff_timing.clk_trail == $past(reg_wdata[`CSI_VAL_MSB:0], 2);
  endproperty
  a_clk_trail: assert property (p_clk_trail) // RULE3
    else $error("clock trail override not held");

  property p_clk_post;
    s_ovr_wr(`CSI_OFS_CLK_POST) |=> ov[`CSI_IDX_CLK_POST];
  endproperty
  a_clk_post: assert property (p_clk_post) // RULE4
    else $error("clock post override bit not set");

  property p_hs_prepare;
    reg_wr && reg_addr == `CSI_OFS_HS_PREP && !reg_wdata[`CSI_OV_BIT] |=>
      eff_timing.hs_prepare == auto_timing.hs_prepare;
  endproperty
  a_hs_prepare: assert property (p_hs_prepare) // RULE5
    else $error("HS prepare not back on automatic value");

  property p_hs_zero;
    s_ovr_wr(`CSI_OFS_HS_ZERO) |=>
      eff_timing.hs_zero == $past(reg_wdata[`CSI_VAL_MSB:0]);
  endproperty
  a_hs_zero: assert property (p_hs_zero) // RULE6
    else $error("HS zero override not applied");

  property p_hs_trail;
    s_ovr_wr(`CSI_OFS_HS_TRAIL) |=>
      eff_timing.hs_trail == $past(reg_wdata[`CSI_VAL_MSB:0]);
  endproperty
  a_hs_trail: assert property (p_hs_trail) // RULE7
    else $error("HS trail override not applied");

  property p_auto_readback;
    reg_rd && hit && !ov[idx] |=>
      reg_rdata == {1'b0, $past(eff_arr[idx])} && !reg_rdata[`CSI_OV_BIT];
  endproperty
  a_auto_readback: assert property (p_auto_readback) // RULE8
    else $error("read with override clear wrong");

  sequence s_wr_then_rd;
    (reg_wr && hit && reg_wdata[`CSI_OV_BIT]) ##1 (reg_rd && !reg_wr && reg_addr == $past(reg_addr));
  endsequence

  property p_ovr_readback;
    s_wr_then_rd |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_ovr_readback: assert property (p_ovr_readback) // RULE9
    else $error("override value not read back");

  property p_clock_before_data;
    $rose(lane_ctrl.data_prep) |-> lane_ctrl.clk_hs && $past(lane_ctrl.clk_hs);
  endproperty
  a_clock_before_data: assert property (p_clock_before_data) // RULE10
    else $error("data lane started before clock lane");

  property p_prep_length;
    state == csi_timing_pkg::ST_IDLE && hs_req
      ##1 (state == csi_timing_pkg::ST_CLK_PREP && cnt == `CSI_MIN_PHASE) |=>
      state == csi_timing_pkg::ST_CLK_ZERO;
  endproperty
  a_prep_length: assert property (p_prep_length) // RULE10
    else $error("clock prepare phase length wrong");

endmodule

`default_nettype wire

// ==== tb/csi_dphy_timing_override_regs_tb_top.sv ====
// Self-checking bench for the lane timing override registers and sequencer
`timescale 1ns/10ps
`default_nettype none
`include "csi_timing_defs.svh"

module csi_dphy_timing_override_regs_tb_top;
  logic                        core_clk;
  logic                        rst_n;
  logic [7:0]                  reg_addr;
  logic [7:0]                  reg_wdata;
  logic                        reg_wr;
  logic                        reg_rd;
  logic [7:0]                  reg_rdata;
  csi_timing_pkg::timing_set_t auto_timing;
  csi_timing_pkg::timing_set_t eff_timing;
  logic                        hs_req;
  csi_timing_pkg::lane_ctrl_t  lane_ctrl;
  int                          bad_count;
  int                          check_count;
  int                          cyc = 0;
  bit                          ovm [7];
  logic [6:0]                  valm [7];

  csi_dphy_timing_override_regs dut_u (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .auto_timing (auto_timing),
    .eff_timing  (eff_timing),
    .hs_req      (hs_req),
    .lane_ctrl   (lane_ctrl)
  );

  // 25 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end

  // Model: value in effect is the software value only while overridden
  function automatic logic [6:0] exp_eff(int i);
    return ovm[i] ? valm[i] : auto_timing[i*7 +: 7];
  endfunction

  // Phase length; a zero value still lasts one cycle
  function automatic int plen(int i);
    return (exp_eff(i) == 7'h00) ? 1 : int'(exp_eff(i));
  endfunction

  task automatic chk8(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t byte %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkn(int got, int exp);
    check_count++;
    if (got != exp) begin
      bad_count++;
      $display("MISMATCH t=%0t count %0d exp %0d", $time, got, exp);
    end
  endtask

  // Every effective value against the model
  task automatic chk_eff();
    for (int i = 0; i < 7; i++) begin
      chk8({1'b0, eff_timing[i*7 +: 7]}, {1'b0, exp_eff(i)});
    end
  endtask

  task automatic rand_auto(int maxv);
    for (int i = 0; i < 7; i++) begin
      auto_timing[i*7 +: 7] <= 7'($urandom_range(maxv, 0));
    end
  endtask

  // Bus write; model follows at the edge that takes it
  task automatic reg_write(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a >= `CSI_OFS_CLK_PREP && a <= `CSI_OFS_HS_TRAIL) begin
      ovm[a - 8'h40] = d[7];
      if (d[7]) valm[a - 8'h40] = d[6:0];
    end
  endtask

  // Bus read; data looked at only in the cycle after the strobe
  task automatic reg_read_chk(logic [7:0] a);
    logic [7:0] e;
    e = 8'h00;
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    if (a >= `CSI_OFS_CLK_PREP && a <= `CSI_OFS_HS_TRAIL) e = {ovm[a - 8'h40], exp_eff(a - 8'h40)};
    #1;
    chk8(reg_rdata, e);
  endtask

  // Write then read back with the strobes back to back
  task automatic reg_wr_rd(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    ovm[a - 8'h40] = d[7];
    if (d[7]) valm[a - 8'h40] = d[6:0];
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk8(reg_rdata, {ovm[a - 8'h40], exp_eff(a - 8'h40)});
  endtask

  // One high-speed burst; phase totals measured between edges of the controls
  task automatic run_seq();
    int n;
    @(posedge core_clk);
    hs_req <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (lane_ctrl.clk_prep !== 1'b1 && n < 10);
    chkn(n, 1);
    chk8({2'b00, lane_ctrl}, 8'h21);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (lane_ctrl.tx_ready !== 1'b1 && n < 700);
    chkn(n, plen(0) + plen(1) + plen(4) + plen(5));
    chk8({2'b00, lane_ctrl}, 8'h17);
    repeat (3) @(posedge core_clk);
    hs_req <= 1'b0;
    @(posedge core_clk);
    #1;
    chk8({7'h00, lane_ctrl.tx_ready}, 8'h00);
    // Clock lane keeps running while the data lane trails
    chk8({2'b00, lane_ctrl}, 8'h15);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (lane_ctrl.busy !== 1'b0 && n < 700);
    chkn(n, plen(6) + plen(3) + plen(2));
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    bad_count   = 0;
    check_count = 0;
    rst_n       = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    hs_req      = 1'b0;
    for (int i = 0; i < 7; i++) begin
      ovm[i]  = 1'b0;
      valm[i] = 7'h00;
    end
    void'($urandom(32'h914d));
    rand_auto(127);
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk8({2'b00, lane_ctrl}, 8'h00);
    chk_eff();
    for (int i = 0; i < 7; i++) reg_read_chk(8'h40 + 8'(i));
    $display("test reset values done");
    // Each register set then cleared, with auto values moving underneath
    for (int i = 0; i < 7; i++) begin
      for (int b = 1; b >= 0; b--) begin
        reg_write(8'h40 + 8'(i), {1'(b), 7'($urandom)});
        #1;
        chk_eff();
        @(posedge core_clk);
        rand_auto(127);
        reg_read_chk(8'h40 + 8'(i));
        chk_eff();
      end
      reg_wr_rd(8'h40 + 8'(i), {1'b1, 7'($urandom)});
    end
    for (int i = 0; i < 7; i++) reg_read_chk(8'h40 + 8'(i));
    $display("test override done");
    // Neighbours of the page stay inert
    reg_write(8'h47, 8'hff);
    reg_read_chk(8'h47);
    reg_read_chk(8'h3f);
    chk_eff();
    $display("test unmapped done");
    // Bursts with a mix of automatic and software phase lengths
    for (int r = 0; r < 4; r++) begin
      @(posedge core_clk);
      rand_auto(6);
      // First burst all overridden to zero, which must still last a cycle per phase
      for (int i = 0; i < 7; i++) begin
        reg_write(8'h40 + 8'(i), (r == 0) ? 8'h80 : {1'($urandom), 7'($urandom_range(5, 0))});
      end
      run_seq();
    end
    $display("test sequencer done");
    summarize();
  end
endmodule
`default_nettype wire
